// file: hw/display_control_registers.sv
/*
  display control register group: enable, attributes, screen block start and size,
  flash timing, cursor stepping on memory access, indirect command loading.
  assumes host strobes and frameTick are synchronous to clk_sys, one cycle wide.
*/
// How it works
// - display enable zero blanks every layer
// - enable overrides all block and cursor attributes
// - bits 7-6 decode block three attribute
// - bits 5-4 serve block two and four
// - bits 3-2 decode block one attribute
// - bits 1-0 decode cursor, slow 32/64
// - flashing cursor shown seven tenths period
// - memory write re-enables hidden cursor, advances
// - memory read advances cursor, keeps hidden
// - block one start formed from two bytes
// - high byte write applies both start bytes
// - block one size is lines minus one
// - display switch parameter loads attribute register
// - scroll parameters fill start and size registers
// - display enable resets zero at 8009h
// - attribute register resets zero at 800Ah
// - power save entry clears display enable
// - dualPanel input selects dual panel
`timescale 1ns/100ps
`default_nettype none
`include "disp_ctrl_defines.svh"
module display_control_registers (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // direct host register access
  input wire disp_ctrl_pkg::regReq_t regReq,
  output logic [7:0] regRdata,
  // indirect commands
  input wire disp_ctrl_pkg::cmdReq_t cmdReq,
  // system context
  input wire logic powerSaveEnter,
  input wire logic dualPanel,
  input wire logic frameTick,
  input wire logic memWrite,
  input wire logic memRead,
  // display outputs
  output disp_ctrl_pkg::visible_t visible,
  output logic displayOn,
  output logic cursorEnabled,
  output logic cursorStep,
  output logic [15:0] block1_start,
  output logic [7:0] block1_lines
);
  import disp_ctrl_pkg::*;

  localparam logic [7:0] CUR_SLOW_SHOW = 8'((`FLASH_DIV_SLOW * `CUR_ON_TENTHS) / 10);
  localparam logic [7:0] CUR_FAST_SHOW = 8'((`FLASH_DIV_CUR_SLOW * `CUR_ON_TENTHS) / 10);

  // register state
  logic dispEn_q, dispEn_d;
  logic [7:0] attr_q, attr_d;
  logic [7:0] startLo_q, startLo_d; // staged low byte
  logic [15:0] start_q, start_d; // applied start address
  logic [7:0] lines_q, lines_d;
  logic curEn_q, curEn_d;
  logic step_q, step_d;
  cmdState_t cmd_q, cmd_d;
  logic [3:0] pIdx_q, pIdx_d; // scroll parameter index
  logic [`FRAME_CNT_W-1:0] frm_q, frm_d;
  visible_t vis_q, vis_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit, scrWr, dualPanel_q;
  logic [3:0] scrIdx;
  logic [7:0] scrData, memRd;
  logic ph32, ph4, curSlow, curFast, shB1, shB2, shB3, shCur;

  // decode a direct address into a register offset, 8'hff when off-page
  function automatic logic [7:0] regOfs(input logic [15:0] a);
    if (a[15:8] == `ADDR_PAGE) begin
      regOfs = a[7:0];
    end else begin
      regOfs = 8'hff;
    end
  endfunction : regOfs

  always_comb begin
    frm_d = frameTick ? frm_q + 1'b1 : frm_q;
  end
  assign ph32 = ~frm_q[4];
  assign ph4 = ~frm_q[1];
  assign curSlow = {3'h0, frm_q[4:0]} < CUR_SLOW_SHOW;
  assign curFast = {2'h0, frm_q} < CUR_FAST_SHOW;

  attr_decode uB3 (.code(attr_q[`FLD_B3_HI:`FLD_B3_LO]), .slowPhase(ph32), .fastPhase(ph4), .shown(shB3));
  attr_decode uB2 (.code(attr_q[`FLD_B2_HI:`FLD_B2_LO]), .slowPhase(ph32), .fastPhase(ph4), .shown(shB2));
  attr_decode uB1 (.code(attr_q[`FLD_B1_HI:`FLD_B1_LO]), .slowPhase(ph32), .fastPhase(ph4), .shown(shB1));
  attr_decode uCur (.code(attr_q[`FLD_CUR_HI:`FLD_CUR_LO]), .slowPhase(curSlow), .fastPhase(curFast),
    .shown(shCur));

  // scroll parameter store for offsets 0Bh..14h; block one copies live locally too
  always_comb begin
    scrWr = 1'b0;
    scrIdx = 4'h0;
    scrData = regReq.data;
    if (cmd_q == CMD_SCROLL && cmdReq.param && pIdx_q < `SCROLL_PARAM_COUNT) begin
      scrWr = 1'b1;
      scrIdx = pIdx_q;
      scrData = cmdReq.data;
    end else if (regReq.wr && regOfs(regReq.addr) >= `OFS_B1_START_LO
                 && regOfs(regReq.addr) <= `OFS_B4_START_HI) begin
      scrWr = 1'b1;
      scrIdx = 4'(regOfs(regReq.addr) - `OFS_B1_START_LO);
    end
  end
  scroll_regs uScroll (.clk_sys(clk_sys), .reset(reset), .wrEn(scrWr), .wrIdx(scrIdx), .wrData(scrData),
    .rdIdx(4'(regOfs(regReq.addr) - `OFS_B1_START_LO)), .rdData(memRd));

  // register writes, commands, cursor and visibility next state
  always_comb begin
    dispEn_d = dispEn_q;
    attr_d = attr_q;
    startLo_d = startLo_q;
    start_d = start_q;
    lines_d = lines_q;
    curEn_d = curEn_q;
    step_d = 1'b0;
    cmd_d = cmd_q;
    pIdx_d = pIdx_q;
    rdata_d = 8'h00;
    hit = 1'b0;
    // direct register writes
    if (regReq.wr) begin
      if (regOfs(regReq.addr) == `OFS_DISPLAY_ON) begin
        dispEn_d = regReq.data[0];
      end else if (regOfs(regReq.addr) == `OFS_ATTRIB) begin
        attr_d = regReq.data;
      end else if (regOfs(regReq.addr) == `OFS_B1_START_LO) begin
        startLo_d = regReq.data;
      end else if (regOfs(regReq.addr) == `OFS_B1_START_HI) begin
        start_d = {regReq.data, startLo_q};
      end else if (regOfs(regReq.addr) == `OFS_B1_LINES) begin
        lines_d = regReq.data;
      end
    end
    // direct register reads, unmapped reads zero
    if (regReq.rd) begin
      if (regOfs(regReq.addr) == `OFS_DISPLAY_ON) begin
        rdata_d = {7'h00, dispEn_q};
      end else if (regOfs(regReq.addr) == `OFS_ATTRIB) begin
        rdata_d = attr_q;
      end else if (regOfs(regReq.addr) >= `OFS_B1_START_LO && regOfs(regReq.addr) <= `OFS_B4_START_HI) begin
        hit = 1'b1;
      end
    end
    // indirect command sequencing
    case (cmd_q)
      CMD_SWITCH: begin
        if (cmdReq.param) begin
          attr_d = cmdReq.data;
          cmd_d = CMD_IDLE;
        end
      end
      CMD_SCROLL: begin
        if (cmdReq.param) begin
          if (pIdx_q == 4'h0) begin
            startLo_d = cmdReq.data;
          end else if (pIdx_q == 4'h1) begin
            start_d = {cmdReq.data, startLo_q};
          end else if (pIdx_q == 4'h2) begin
            lines_d = cmdReq.data;
          end
          pIdx_d = pIdx_q + 4'h1;
          if (pIdx_q == `SCROLL_PARAM_COUNT - 4'h1) begin
            cmd_d = CMD_IDLE;
          end
        end
      end
      default: begin
        cmd_d = CMD_IDLE;
      end
    endcase
    // a new command aborts any parameter walk
    if (cmdReq.dispSwitch) begin
      cmd_d = CMD_SWITCH;
      // display switch command turns the display on
      dispEn_d = 1'b1;
    end else if (cmdReq.scroll) begin
      cmd_d = CMD_SCROLL;
      pIdx_d = 4'h0;
    end
    if (memWrite) begin
      curEn_d = 1'b1;
      step_d = 1'b1;
    end else if (memRead) begin
      step_d = 1'b1;
    end
    if (powerSaveEnter) begin
      dispEn_d = 1'b0;
    end
  end

  always_comb begin
    vis_d.block1 = dispEn_q & shB1;
    vis_d.block2 = dispEn_q & shB2;
    vis_d.block3 = dispEn_q & shB3;
    vis_d.block4 = dispEn_q & dualPanel_q & shB2;
    vis_d.cursor = dispEn_q & curEn_q & shCur;
  end

  // registers only; reset zero except curEn_q, which resets to one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dispEn_q <= 1'b0;
      attr_q <= `RST_BYTE;
      startLo_q <= `RST_BYTE;
      start_q <= 16'h0000;
      lines_q <= `RST_BYTE;
      curEn_q <= 1'b1;
      step_q <= 1'b0;
      cmd_q <= CMD_IDLE;
      pIdx_q <= 4'h0;
      frm_q <= '0;
      vis_q <= '0;
      rdata_q <= 8'h00;
      dualPanel_q <= 1'b0;
    end else begin
      dispEn_q <= dispEn_d;
      attr_q <= attr_d;
      startLo_q <= startLo_d;
      start_q <= start_d;
      lines_q <= lines_d;
      curEn_q <= curEn_d;
      step_q <= step_d;
      cmd_q <= cmd_d;
      pIdx_q <= pIdx_d;
      frm_q <= frm_d;
      vis_q <= vis_d;
      rdata_q <= rdata_d;
      dualPanel_q <= dualPanel;
    end
  end

  // stored read data is registered on the same edge as the register ones; merge after
  logic hit_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
    end
  end
  assign regRdata = hit_q ? memRd : rdata_q;

  assign visible = vis_q;
  assign displayOn = dispEn_q;
  assign cursorEnabled = curEn_q;
  assign cursorStep = step_q;
  assign block1_start = start_q;
  assign block1_lines = lines_q;

  // display off forces all blank
  blank_when_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    !dispEn_q |=> vis_q == '0) else $error("layer visible while display off");
  // enable beats any attribute
  override_attr_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!dispEn_q && attr_q != 8'h00) |=> !vis_q.cursor && !vis_q.block1) else $error("attribute beat enable");
  // steady block three follows enable
  block3_steady_a: assert property (@(posedge clk_sys) disable iff (reset)
    (dispEn_q && attr_q[7:6] == 2'h1) |=> vis_q.block3) else $error("steady block three hidden");
  // block four mirrors block two only in dual panel
  block4_share_a: assert property (@(posedge clk_sys) disable iff (reset)
    vis_q.block4 |-> $past(dualPanel_q) && vis_q.block2) else $error("block four mismatch");
  // block one blank code hides it
  block1_blank_a: assert property (@(posedge clk_sys) disable iff (reset)
    (attr_q[3:2] == 2'h0) |=> !vis_q.block1) else $error("blank block one shown");
  // hidden cursor code blanks cursor
  cursor_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    (attr_q[1:0] == 2'h0) |=> !vis_q.cursor) else $error("cursor shown while off");
  // write enables cursor and steps
  sequence memWr_s;
    memWrite;
  endsequence
  write_cursor_a: assert property (@(posedge clk_sys) disable iff (reset)
    memWr_s |=> curEn_q && step_q) else $error("write did not enable cursor");
  // read keeps hidden cursor hidden
  read_cursor_a: assert property (@(posedge clk_sys) disable iff (reset)
    (memRead && !memWrite) |=> $stable(curEn_q) && step_q) else $error("read changed cursor");
  // low byte alone leaves start
  start_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (regReq.wr && regOfs(regReq.addr) == `OFS_B1_START_LO && cmd_q == CMD_IDLE)
    |=> $stable(start_q)) else $error("start moved before high byte");
  // power save clears enable
  power_save_a: assert property (@(posedge clk_sys) disable iff (reset)
    powerSaveEnter |=> !dispEn_q ##1 !vis_q.block1) else $error("power save left display on");
endmodule : display_control_registers
`default_nettype wire

// file: hw/disp_ctrl_defines.svh
/*
  constants of the display control register group: offsets, fields, resets, timing.
  assumes inclusion by its bare name from the package and the design files.
*/
`ifndef DISP_CTRL_DEFINES_SVH
`define DISP_CTRL_DEFINES_SVH
`define OFS_DISPLAY_ON 8'h09
`define OFS_ATTRIB 8'h0a
`define OFS_B1_START_LO 8'h0b
`define OFS_B1_START_HI 8'h0c
`define OFS_B1_LINES 8'h0d
`define OFS_B4_START_HI 8'h14
`define ADDR_PAGE 8'h80
`define RST_BYTE 8'h00
`define FLD_B3_HI 7
`define FLD_B3_LO 6
`define FLD_B2_HI 5
`define FLD_B2_LO 4
`define FLD_B1_HI 3
`define FLD_B1_LO 2
`define FLD_CUR_HI 1
`define FLD_CUR_LO 0
`define FLASH_DIV_SLOW 32
`define FLASH_DIV_FAST 4
`define FLASH_DIV_CUR_SLOW 64
`define CUR_ON_TENTHS 7
`define SCROLL_PARAM_COUNT 4'h0a
`define FRAME_CNT_W 6
`endif

// file: hw/disp_ctrl_pkg.sv
/*
  types shared by the display control register group.
  assumes the defines header is on the include path.
*/
`include "disp_ctrl_defines.svh"
package disp_ctrl_pkg;
  // host register access, one byte
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } regReq_t;
  // indirect command strobes
  typedef struct packed {
    logic dispSwitch;
    logic scroll;
    logic param;
    logic [7:0] data;
  } cmdReq_t;
  // visibility of each layer
  typedef struct packed {
    logic block1;
    logic block2;
    logic block3;
    logic block4;
    logic cursor;
  } visible_t;
  // host command sequencer
  typedef enum logic [1:0] {CMD_IDLE = 2'b00, CMD_SWITCH = 2'b01, CMD_SCROLL = 2'b11} cmdState_t;
endpackage : disp_ctrl_pkg

// file: hw/attr_decode.sv
/*
  turns a two bit attribute code plus flash phases into a visible flag.
  assumes the phase inputs are decoded by the caller from its frame counter, on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module attr_decode (
  // attribute code and phases
  input wire logic [1:0] code,
  input wire logic slowPhase,
  input wire logic fastPhase,
  // result
  output logic shown
);
  // 00 blank, 01 steady, 10 slow flash, 11 fast flash
  always_comb begin
    case (code)
      2'h0: shown = 1'b0;
      2'h1: shown = 1'b1;
      2'h2: shown = slowPhase;
      default: shown = fastPhase;
    endcase
  end
endmodule : attr_decode
`default_nettype wire

// file: hw/scroll_regs.sv
/*
  small register memory of the scroll parameters, block 1 start to block 4 start high.
  assumes one write per cycle; read data comes out of a register.
*/
`timescale 1ns/100ps
`default_nettype none
module scroll_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // write port, index relative to block 1 start low
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire logic [7:0] wrData,
  // read port
  input wire logic [3:0] rdIdx,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:9];
  logic [7:0] rdData_d;
  // registered read, unmapped index reads zero
  always_comb begin
    rdData_d = (rdIdx < 4'ha) ? mem[rdIdx] : 8'h00;
  end
  // every word resets to zero
  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : gWord
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          mem[g] <= 8'h00;
        end else if (wrEn && wrIdx == 4'(g)) begin
          mem[g] <= wrData;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData <= 8'h00;
    end else begin
      rdData <= rdData_d;
    end
  end
endmodule : scroll_regs
`default_nettype wire

// file: bench/host_model.sv
/*
  host processor model: direct register strokes, indirect command bytes, memory strobes.
  assumes calls start just after a rising clk_sys edge.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_sys,
  // host requests
  output disp_ctrl_pkg::regReq_t regReq,
  output disp_ctrl_pkg::cmdReq_t cmdReq,
  output logic memWrite,
  output logic memRead,
  // read return
  input wire logic [7:0] regRdata
);
  import disp_ctrl_pkg::*;
  initial begin
    regReq = '0;
    cmdReq = '0;
    memWrite = 1'b0;
    memRead = 1'b0;
  end
  // one strobe, then a quiet cycle so no strobe is driven twice in one step
  task regWrite(input logic [15:0] a, input logic [7:0] d);
    regReq.addr = a;
    regReq.data = d;
    regReq.wr = 1'b1;
    @(posedge clk_sys);
    #1 regReq.wr = 1'b0;
    // released data bus shows no stale value
    regReq.data = ~d;
    @(posedge clk_sys);
    #1;
  endtask : regWrite
  // data registered at the taking edge, sampled just after it
  task regRead(input logic [15:0] a, output logic [7:0] d);
    regReq.addr = a;
    regReq.rd = 1'b1;
    @(posedge clk_sys);
    #1 regReq.rd = 1'b0;
    d = regRdata;
    @(posedge clk_sys);
    #1;
  endtask : regRead
  task setStart(input logic [15:0] s);
    regWrite(16'h800b, s[7:0]);
    regWrite(16'h800c, s[15:8]);
  endtask : setStart
  // kind: 0 parameter, 1 display switch, 2 scroll
  task cmdByte(input logic [1:0] kind, input logic [7:0] d);
    cmdReq.param = (kind == 2'h0);
    cmdReq.dispSwitch = (kind == 2'h1);
    cmdReq.scroll = (kind == 2'h2);
    cmdReq.data = d;
    @(posedge clk_sys);
    #1 cmdReq = '0;
    @(posedge clk_sys);
    #1;
  endtask : cmdByte
  task memAccess(input logic isWrite);
    memWrite = isWrite;
    memRead = ~isWrite;
    @(posedge clk_sys);
    #1 memWrite = 1'b0;
    memRead = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : memAccess
endmodule : host_model
`default_nettype wire

// file: bench/display_control_registers_tb_top.sv
/*
  self-checking bench of the display control register group.
  assumes the design package and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module display_control_registers_tb_top;
  import disp_ctrl_pkg::*;
  logic clk_sys, reset, powerSaveEnter, dualPanel, frameTick, memWrite, memRead;
  logic displayOn, cursorEnabled, cursorStep;
  logic [7:0] regRdata, block1_lines, rdVal;
  logic [15:0] block1_start;
  regReq_t regReq;
  cmdReq_t cmdReq;
  visible_t visible;
  int errCount = 0;
  int totalChecks = 0;
  int stepCount = 0;
  display_control_registers dut (.clk_sys(clk_sys), .reset(reset), .regReq(regReq), .regRdata(regRdata),
    .cmdReq(cmdReq), .powerSaveEnter(powerSaveEnter), .dualPanel(dualPanel), .frameTick(frameTick),
    .memWrite(memWrite), .memRead(memRead), .visible(visible), .displayOn(displayOn),
    .cursorEnabled(cursorEnabled), .cursorStep(cursorStep), .block1_start(block1_start),
    .block1_lines(block1_lines));
  host_model host (.clk_sys(clk_sys), .regReq(regReq), .cmdReq(cmdReq), .memWrite(memWrite),
    .memRead(memRead), .regRdata(regRdata));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // pulse counter, so a stretched step pulse shows up as an extra count;
  // sampled on the falling edge, away from the edge that launches the pulse
  always @(negedge clk_sys) begin
    if (cursorStep === 1'b1) stepCount++;
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : giveVerdict
  task settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  task readChk(input string what, input logic [15:0] a, input logic [7:0] exp);
    host.regRead(a, rdVal);
    chk(what, {8'h00, exp}, {8'h00, rdVal});
  endtask : readChk
  task checkResetValues();
    for (int i = 9; i <= 13; i++) readChk("reset reg", 16'h8000 + i[15:0], 8'h00);
    chk("enable out", 16'h0, {15'h0, displayOn});
    chk("visible", 16'h0, {11'h0, visible});
    readChk("unmapped", 16'h8020, 8'h00);
    host.regWrite(16'h0009, 8'h01);
    settle();
    chk("off page", 16'h0, {15'h0, displayOn});
  endtask : checkResetValues
  task checkStartAddress();
    host.regWrite(16'h800b, 8'h34);
    settle();
    chk("start held", 16'h0000, block1_start);
    host.regWrite(16'h800c, 8'h12);
    settle();
    chk("start applied", 16'h1234, block1_start);
    host.regWrite(16'h800d, 8'h5f);
    settle();
    chk("lines", 16'h005f, {8'h00, block1_lines});
  endtask : checkStartAddress
  task checkEnableOverride();
    logic [7:0] attr [7] = '{8'h55, 8'h55, 8'h04, 8'h10, 8'h40, 8'h01, 8'hff};
    logic [4:0] exp [7] = '{5'h00, 5'h1f, 5'h10, 5'h0a, 5'h04, 5'h01, 5'h00};
    dualPanel = 1'b1;
    for (int i = 0; i < 7; i++) begin
      host.regWrite(16'h8009, {7'h0, i > 0 && i < 6});
      host.regWrite(16'h800a, attr[i]);
      settle();
      chk("field visible", {11'h0, exp[i]}, {11'h0, visible});
    end
    dualPanel = 1'b0;
    host.regWrite(16'h8009, 8'h01);
    host.regWrite(16'h800a, 8'h10);
    settle();
    chk("single panel", 16'h0008, {11'h0, visible});
  endtask : checkEnableOverride
  // 64 frames: blocks shown half of them, cursor 44; fast layers toggle often
  task checkFlash(input logic [7:0] attr, input logic [4:0] fastMask, input logic cur32);
    int onCnt [5];
    int tog [5];
    logic [4:0] prev;
    dualPanel = 1'b1;
    host.regWrite(16'h800a, attr);
    onCnt = '{0, 0, 0, 0, 0};
    tog = '{0, 0, 0, 0, 0};
    settle();
    prev = visible;
    for (int f = 0; f < 64; f++) begin
      frameTick = 1'b1;
      @(posedge clk_sys);
      #1 frameTick = 1'b0;
      settle();
      for (int b = 0; b < 5; b++) begin
        onCnt[b] += visible[b];
        tog[b] += (visible[b] != prev[b]);
      end
      prev = visible;
    end
    for (int b = 1; b < 5; b++) begin
      chk("block on frames", 16'd32, onCnt[b][15:0]);
      chk("fast toggling", {15'h0, fastMask[b]}, {15'h0, tog[b] > 16});
    end
    chk("cursor on frames", 16'd44, onCnt[0][15:0]);
    chk("cursor rate", {15'h0, cur32}, {15'h0, tog[0] > 2});
  endtask : checkFlash
  task checkPowerSave();
    host.regWrite(16'h8009, 8'h01);
    powerSaveEnter = 1'b1;
    @(posedge clk_sys);
    #1 powerSaveEnter = 1'b0;
    settle();
    chk("power save", 16'h0, {15'h0, displayOn});
    readChk("enable reg", 16'h8009, 8'h00);
    host.regWrite(16'h8009, 8'h01);
    settle();
    chk("re-enable", 16'h1, {15'h0, displayOn});
  endtask : checkPowerSave
  task checkCommands();
    host.regWrite(16'h8009, 8'h00);
    host.cmdByte(2'h1, 8'h00);
    host.cmdByte(2'h0, 8'h41);
    readChk("switch param", 16'h800a, 8'h41);
    chk("switch on", 16'h1, {15'h0, displayOn});
    host.cmdByte(2'h2, 8'h00);
    for (int i = 0; i < 11; i++) host.cmdByte(2'h0, 8'h20 + i[7:0]);
    for (int i = 0; i < 10; i++) readChk("scroll param", 16'h800b + i[15:0], 8'h20 + i[7:0]);
    settle();
    chk("scroll start", 16'h2120, block1_start);
    chk("scroll lines", 16'h0022, {8'h00, block1_lines});
    // host model writes low byte first, then high byte
    host.setStart(16'h5678);
    settle();
    chk("start via host", 16'h5678, block1_start);
  endtask : checkCommands
  task checkMemAccess();
    host.memAccess(1'b1);
    host.memAccess(1'b0);
    settle();
    chk("step pulses", 16'd2, stepCount[15:0]);
    chk("cursor enabled", 16'h1, {15'h0, cursorEnabled});
  endtask : checkMemAccess
  initial begin
    reset = 1'b1;
    powerSaveEnter = 1'b0;
    dualPanel = 1'b0;
    frameTick = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    checkResetValues();
    checkStartAddress();
    checkEnableOverride();
    checkFlash(8'hba, 5'b01010, 1'b1);
    checkFlash(8'hef, 5'b10100, 1'b0);
    checkPowerSave();
    checkCommands();
    checkMemAccess();
    giveVerdict();
  end
  // watchdog cuts a hang short
  initial begin
    #200000;
    errCount++;
    giveVerdict();
  end
endmodule : display_control_registers_tb_top
`default_nettype wire
